// File: verilog/lsbu_regs.vh
// Purpose: constants for the logic, shift and bit operation unit
// Assumes: plain Verilog-2005, included by bare name
// Notes:   opcode and size encodings are local to this unit
`ifndef LSBU_REGS_VH
`define LSBU_REGS_VH

`define LSBU_SZ_BYTE    2'h0
`define LSBU_SZ_WORD    2'h1
`define LSBU_SZ_LONG    2'h2

`define LSBU_OP_AND     5'h00
`define LSBU_OP_OR      5'h01
`define LSBU_OP_XOR     5'h02
`define LSBU_OP_NOT     5'h03
`define LSBU_OP_ASL     5'h04
`define LSBU_OP_ASR     5'h05
`define LSBU_OP_LSL     5'h06
`define LSBU_OP_LSR     5'h07
`define LSBU_OP_ROL     5'h08
`define LSBU_OP_ROR     5'h09
`define LSBU_OP_RCL     5'h0a
`define LSBU_OP_RCR     5'h0b
`define LSBU_OP_BSET1   5'h0c
`define LSBU_OP_BSET0   5'h0d
`define LSBU_OP_BTGL    5'h0e
`define LSBU_OP_BPROBE  5'h0f
`define LSBU_OP_CANDB   5'h10
`define LSBU_OP_CANDIB  5'h11
`define LSBU_OP_CORB    5'h12
`define LSBU_OP_CORIB   5'h13

`define LSBU_C_RST      1'h0
`define LSBU_Z_RST      1'h0
`define LSBU_RES_RST    32'h0000_0000

`endif

// File: verilog/lsbu_bitsel.v
// Purpose: byte bit select and single bit modify
// Assumes: pure combinational, bit position already resolved
// Notes:   shared by the modify and the carry-logic bit operations
module lsbu_bitsel (
	input  wire [7:0] byte_in,
	input  wire [2:0] pos,
	input  wire [1:0] mode,
	output wire       bit_out,
	output wire [7:0] byte_out
);
	// mode 0: force one, 1: force zero, 2: toggle, 3: unchanged
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_bit
			localparam [2:0] IDX = i;
			wire hit;
			assign hit = (pos == IDX);
			assign byte_out[i] = !hit ? byte_in[i] :
				(mode == 2'h0) ? 1'b1 :
				(mode == 2'h1) ? 1'b0 :
				(mode == 2'h2) ? ~byte_in[i] : byte_in[i];
		end
	endgenerate
	assign bit_out = byte_in[pos];
endmodule

// File: verilog/lsbu_core.v
// Purpose: logic, shift/rotate and single-bit datapath of the core
// Assumes: operands come from the decoder on the core clock; one op per cycle
// Notes:   result and flags are registered; flags not named by an op hold
`include "lsbu_regs.vh"
module lsbu_core (
	input  wire        clk,
	input  wire        rstn,
	input  wire        op_valid,
	input  wire [4:0]  op_code,
	input  wire [1:0]  op_size,
	input  wire [31:0] dst_val,
	input  wire [31:0] src_val,
	input  wire        src_is_imm,
	input  wire [31:0] imm_val,
	input  wire [2:0]  bit_imm,
	input  wire        bit_from_reg,
	input  wire        carry_in,
	input  wire        zero_in,
	output reg  [31:0] res_q,
	output reg         res_we_q,
	output reg         carry_q,
	output reg         zero_q,
	output reg         flag_we_q,
	output reg         op_done_q
);
	reg  [31:0] res_d;
	reg         res_we_d;
	reg         carry_d;
	reg         zero_d;
	reg         flag_we_d;
	reg  [31:0] mask;
	reg  [31:0] dmask;
	reg         msb;
	reg         lsb_out;
	reg  [1:0]  bmode;
	wire [31:0] opnd;
	wire [2:0]  pos;
	wire        sel_bit;
	wire [7:0]  mod_byte;
	wire        imm_only;

	assign opnd = src_is_imm ? imm_val : src_val;
	assign imm_only = (op_code == `LSBU_OP_CANDIB) || (op_code == `LSBU_OP_CORIB);
	// the inverted carry ops ignore the register select so bad decodes cannot reach them
	assign pos = (bit_from_reg && !imm_only) ? src_val[2:0] : bit_imm;

	lsbu_bitsel u_bitsel (
		.byte_in  (dst_val[7:0]),
		.pos      (pos),
		.mode     (bmode),
		.bit_out  (sel_bit),
		.byte_out (mod_byte)
	);

	always @* begin
		case (op_code)
			`LSBU_OP_BSET1: bmode = 2'h0;
			`LSBU_OP_BSET0: bmode = 2'h1;
			`LSBU_OP_BTGL:  bmode = 2'h2;
			default:        bmode = 2'h3;
		endcase
	end

	always @* begin
		case (op_size)
			`LSBU_SZ_BYTE: begin
				mask = 32'h0000_00ff;
				msb  = dst_val[7];
			end
			`LSBU_SZ_WORD: begin
				mask = 32'h0000_ffff;
				msb  = dst_val[15];
			end
			default: begin
				mask = 32'hffff_ffff;
				msb  = dst_val[31];
			end
		endcase
		dmask = dst_val & mask;
		lsb_out = dst_val[0];
	end

	always @* begin
		// bits above the operand size are kept so a byte op leaves the upper register alone
		res_d     = dst_val;
		res_we_d  = 1'b0;
		carry_d   = carry_in;
		zero_d    = zero_in;
		flag_we_d = 1'b0;
		case (op_code)
			`LSBU_OP_AND: begin
				res_d    = (dst_val & ~mask) | (dst_val & opnd & mask);
				res_we_d = 1'b1;
			end
			`LSBU_OP_OR: begin
				res_d    = (dst_val & ~mask) | ((dst_val | opnd) & mask);
				res_we_d = 1'b1;
			end
			`LSBU_OP_XOR: begin
				res_d    = (dst_val & ~mask) | ((dst_val ^ opnd) & mask);
				res_we_d = 1'b1;
			end
			`LSBU_OP_NOT: begin
				res_d    = (dst_val & ~mask) | (~dst_val & mask);
				res_we_d = 1'b1;
			end
			`LSBU_OP_ASL, `LSBU_OP_LSL: begin
				res_d     = (dst_val & ~mask) | ({dmask[30:0], 1'b0} & mask);
				res_we_d  = 1'b1;
				carry_d   = msb;
				flag_we_d = 1'b1;
			end
			`LSBU_OP_ASR: begin
				res_d     = (dst_val & ~mask) | ((({1'b0, dmask[31:1]}) | (msb ? (mask & ~(mask >> 1)) : 32'h0))
				            & mask);
				res_we_d  = 1'b1;
				carry_d   = lsb_out;
				flag_we_d = 1'b1;
			end
			`LSBU_OP_LSR: begin
				res_d     = (dst_val & ~mask) | ({1'b0, dmask[31:1]} & mask);
				res_we_d  = 1'b1;
				carry_d   = lsb_out;
				flag_we_d = 1'b1;
			end
			`LSBU_OP_ROL: begin
				res_d     = (dst_val & ~mask) | (({dmask[30:0], msb}) & mask);
				res_we_d  = 1'b1;
			end
			`LSBU_OP_ROR: begin
				res_d     = (dst_val & ~mask) | (({1'b0, dmask[31:1]} | (lsb_out ? (mask & ~(mask >> 1)) : 32'h0))
				            & mask);
				res_we_d  = 1'b1;
			end
			`LSBU_OP_RCL: begin
				res_d     = (dst_val & ~mask) | (({dmask[30:0], carry_in}) & mask);
				res_we_d  = 1'b1;
				carry_d   = msb;
				flag_we_d = 1'b1;
			end
			`LSBU_OP_RCR: begin
				res_d     = (dst_val & ~mask) | (({1'b0, dmask[31:1]} | (carry_in ? (mask & ~(mask >> 1)) : 32'h0))
				            & mask);
				res_we_d  = 1'b1;
				carry_d   = lsb_out;
				flag_we_d = 1'b1;
			end
			`LSBU_OP_BSET1, `LSBU_OP_BSET0, `LSBU_OP_BTGL: begin
				res_d    = {dst_val[31:8], mod_byte};
				res_we_d = 1'b1;
			end
			`LSBU_OP_BPROBE: begin
				zero_d    = ~sel_bit;
				flag_we_d = 1'b1;
			end
			`LSBU_OP_CANDB: begin
				carry_d   = carry_in & sel_bit;
				flag_we_d = 1'b1;
			end
			`LSBU_OP_CANDIB: begin
				carry_d   = carry_in & ~sel_bit;
				flag_we_d = 1'b1;
			end
			`LSBU_OP_CORB: begin
				carry_d   = carry_in | sel_bit;
				flag_we_d = 1'b1;
			end
			`LSBU_OP_CORIB: begin
				carry_d   = carry_in | ~sel_bit;
				flag_we_d = 1'b1;
			end
			default: begin
				res_we_d = 1'b0;
			end
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			res_q     <= `LSBU_RES_RST;
			res_we_q  <= 1'b0;
			carry_q   <= `LSBU_C_RST;
			zero_q    <= `LSBU_Z_RST;
			flag_we_q <= 1'b0;
			op_done_q <= 1'b0;
		end else begin
			op_done_q <= op_valid;
			res_we_q  <= op_valid & res_we_d;
			flag_we_q <= op_valid & flag_we_d;
			if (op_valid) begin
				res_q   <= res_d;
				carry_q <= carry_d;
				zero_q  <= zero_d;
			end
		end
	end
endmodule

// File: dv/lsbu_core_props.sv
// Purpose: port checks of lsbu_core
// Assumes: one clock, rstn async active low
// Notes: low byte compared, so every op size fits
`include "lsbu_regs.vh"
module lsbu_core_props (
	input wire        clk,
	input wire        rstn,
	input wire        op_valid,
	input wire        src_is_imm,
	input wire        bit_from_reg,
	input wire        carry_in,
	input wire        res_we_q,
	input wire        carry_q,
	input wire        zero_q,
	input wire        flag_we_q,
	input wire        op_done_q,
	input wire [4:0]  op_code,
	input wire [2:0]  bit_imm,
	input wire [31:0] dst_val,
	input wire [31:0] src_val,
	input wire [31:0] imm_val,
	input wire [31:0] res_q
);
	timeunit 1ns / 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire [4:0] oc = op_valid ? op_code : 5'h1f;
	wire       pi = dst_val[bit_imm];
	wire       pr = dst_val[src_val[2:0]];
	wire [7:0] and_b = dst_val[7:0] & imm_val[7:0];
	wire [7:0] xor_b = dst_val[7:0] ^ src_val[7:0];
	wire [7:0] inv_b = ~dst_val[7:0];
	done_a: assert property (op_valid |=> op_done_q) else $error("no done");
	idle_a: assert property (!op_valid |=> !op_done_q && !res_we_q && $stable(res_q)) else $error("idle");
	and_a: assert property (oc == `LSBU_OP_AND && src_is_imm |=> res_q[7:0] == $past(and_b)) else $error("and");
	xor_a: assert property (oc == `LSBU_OP_XOR && !src_is_imm |=> res_q[7:0] == $past(xor_b)) else $error("xor");
	not_a: assert property (oc == `LSBU_OP_NOT |=> res_q[7:0] == $past(inv_b)) else $error("not");
	bit_force_one_a: assert property (oc == `LSBU_OP_BSET1 && !bit_from_reg |=> res_q[$past(bit_imm)]) else $error("set");
	probe_a: assert property (oc == `LSBU_OP_BPROBE |=> ##0 zero_q != $past(pi) || $past(bit_from_reg))
		else $error("probe");
	candib_a: assert property (oc == `LSBU_OP_CANDIB |=> carry_q == ($past(carry_in) && !$past(pi)))
		else $error("candib");
	probe_we_a: assert property (oc == `LSBU_OP_BPROBE |=> flag_we_q && !res_we_q) else $error("probe strobes");
	and_we_a: assert property (oc == `LSBU_OP_AND |=> res_we_q && !flag_we_q) else $error("and strobes");
	cover property (oc == `LSBU_OP_RCL);
	cover property (oc == `LSBU_OP_CANDIB && bit_from_reg);
	cover property (oc == `LSBU_OP_BPROBE && bit_from_reg && pr);
endmodule
bind lsbu_core lsbu_core_props u_props (.*);

// File: dv/lsbu_seq_model.sv
// Purpose: sequencer side flag store for lsbu_core
// Assumes: flags come back on flag_we_q
// Notes: bench may preset the carry seen by the core to start a carry chain
module lsbu_seq_model (
	input  wire clk,
	input  wire rstn,
	input  wire flag_we_q,
	input  wire carry_q,
	input  wire zero_q,
	input  wire preset_en,
	input  wire preset_c,
	output wire c_fb,
	output reg  z_q
);
	timeunit 1ns / 1ns;
	reg c_q;
	assign c_fb = preset_en ? preset_c : c_q;
	always @(posedge clk or negedge rstn)
		if (!rstn)
			{c_q, z_q} <= 2'h0;
		else if (flag_we_q)
			{c_q, z_q} <= {carry_q, zero_q};
endmodule

// File: dv/lsbu_core_bench.sv
// Purpose: directed bench for lsbu_core
// Assumes: one op in flight, checked the cycle after issue
// Notes: byte 4d is no bit palindrome, so a wrong position source shows
`include "lsbu_regs.vh"
module lsbu_core_bench;
	timeunit 1ns / 1ns;
	localparam [31:0] D = 32'h1234_564d, S = 32'h0ff0_0f3c;
	localparam [63:0] E = 64'h02c0_0240_03c0_02c0;
	reg         clk = 1'h0, rstn = 1'h0, op_valid = 1'h0, src_is_imm = 1'h0, bit_from_reg = 1'h0;
	reg         preset_en = 1'h0, preset_c = 1'h0;
	reg  [4:0]  op_code = 5'h00;
	reg  [1:0]  op_size = 2'h0;
	reg  [2:0]  bit_imm = 3'h0;
	reg  [31:0] dst_val = D, src_val = 32'h0, imm_val = 32'h0, m, r;
	wire [31:0] res_q;
	wire        res_we_q, carry_q, zero_q, flag_we_q, op_done_q, c_fb, z_q;
	integer     fail_count = 0, checked = 0, cyc = 0, ci = -1, k, j;
	lsbu_core dut (.*, .carry_in(c_fb), .zero_in(z_q));
	lsbu_seq_model pm (.*);
	initial forever #5 clk = ~clk;
	task end_of_test;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task cmp(input [31:0] e, input [31:0] g);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// carry preset overrides the stored flag only while the op is offered
	task op(input [4:0] c, input [1:0] sz, input [31:0] s, input im, input fr);
		@(posedge clk) #1 {preset_en, preset_c} = {ci >= 0, ci[0]};
		ci = -1;
		{op_valid, op_code, op_size, src_is_imm, bit_from_reg} = {1'h1, c, sz, im, fr};
		src_val = im ? ~s : s;
		imm_val = im ? s : ~s;
		bit_imm = fr ? ~s[2:0] : s[2:0];
		@(posedge clk) #1 op_valid = 1'h0;
		preset_en = 1'h0;
	endtask
	task t_logic;
		for (k = 0; k < 12; k++) begin
			m = k < 4 ? 32'hff : k < 8 ? 32'hffff : 32'hffff_ffff;
			r = k % 4 == 0 ? D & S : k % 4 == 1 ? D | S : k % 4 == 2 ? D ^ S : ~D;
			op(5'(k % 4), 2'(k / 4), S, k[2], 1'h0);
			cmp(D & ~m | r & m, res_q);
		end
	endtask
	task t_bits;
		for (k = 0; k < 16; k++) begin
			for (j = 0; j < 3; j++) begin
				r = 32'h1 << k % 8;
				op(`LSBU_OP_BSET1 + 5'(j), `LSBU_SZ_LONG, k % 8, k < 8, k > 7);
				cmp(j == 0 ? D | r : j == 1 ? D & ~r : D ^ r, res_q);
			end
			op(`LSBU_OP_BPROBE, `LSBU_SZ_BYTE, k % 8, k < 8, k > 7);
			cmp(!D[k % 8], zero_q);
		end
	endtask
	task t_carry;
		for (k = 0; k < 16; k++) begin
			ci = k % 2;
			j = k / 2 % 4;
			m = k > 7 ? 7 : 0;
			op(`LSBU_OP_CANDB + 5'(j), `LSBU_SZ_BYTE, j % 2 ? ~m : m, !j[0], j[0]);
			r = j % 2 ? !D[m] : D[m];
			cmp(j < 2 ? k % 2 & r : k % 2 | r, carry_q);
		end
	endtask
	task t_shift;
		dst_val = 32'h5a5a_5a81;
		for (k = 0; k < 8; k++) begin
			if (k == 6) ci = 0;
			op(5'h04 + 5'(k), `LSBU_SZ_BYTE, 32'h0, 1'h0, 1'h0);
			cmp({24'h5a5a5a, E[63 - 8 * k -: 8]}, res_q);
			if (k < 4 || k > 5) cmp(32'h1, carry_q);
		end
	endtask
	always @(posedge clk)
		if (++cyc == 1000) begin
			fail_count++;
			end_of_test;
		end
	initial begin
		repeat (12) @(posedge clk);
		#1 rstn = 1'h1;
		t_logic;
		t_bits;
		t_carry;
		t_shift;
		end_of_test;
	end
endmodule
